// [verilog/cii_cpu_iface.sv]
// Interrupt CPU interface: control fields, completion and deactivate handling
module cii_cpu_iface
  import cii_pkg::*;
#(
  parameter bit TWO_SEC = 1'b1,   // Two security states present
  parameter bit LEGACY  = 1'b1    // Legacy bypass lines supported
) (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        nonsecure_i,
  input  wire logic        id_group1_i,
  input  wire logic        sre_el1_i,
  input  wire logic        grp0_pending_i,
  input  wire logic        grp1_pending_i,
  input  wire logic        bypass_fiq_i,
  input  wire logic        hp_active_secure_i,
  output logic      [31:0] rdata_o,
  output logic             rd_valid_o,
  output logic             irq_o,
  output logic             fiq_o,
  output logic             drop_o,
  output logic             deact_o,
  output logic             group1_o,
  output logic      [23:0] int_id_o,
  output logic             clr_s_highest_o,
  output logic             clr_ns_highest_o,
  output logic             sys_err_o,
  output logic      [2:0]  grp0_bp_o,
  output logic      [2:0]  grp1_bp_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Identifier decode

  cii_id_if id_if ();

  assign id_if.raw = wdata_i;

  cii_id_decode u_dec (
    .id_if (id_if)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic        grp0_en_reg,   grp0_en_next;
  logic        grp1_en_reg,   grp1_en_next;
  logic        route_reg,     route_next;
  logic        cbp_reg,       cbp_next;
  logic        bypdis_reg,    bypdis_next;
  logic        split_s_reg,   split_s_next;
  logic        split_ns_reg,  split_ns_next;
  logic [2:0]  bp_s_reg,      bp_s_next;
  logic [2:0]  bp_ns_reg,     bp_ns_next;
  logic [31:0] rdata_reg,     rdata_next;
  logic        rvalid_reg,    rvalid_next;
  logic        irq_reg,       irq_next;
  logic        fiq_reg,       fiq_next;
  logic        drop_reg,      drop_next;
  logic        deact_reg,     deact_next;
  logic        grp1_reg,      grp1_next;
  logic [23:0] id_reg,        id_next;
  logic        clr_s_reg,     clr_s_next;
  logic        clr_ns_reg,    clr_ns_next;
  logic        err_reg,       err_next;
  logic [2:0]  bp0_reg,       bp0_next;
  logic [2:0]  bp1_reg,       bp1_next;

  logic        ns_acc;
  logic        split_acc;
  logic        hit_ctl;
  logic        hit_bp;
  logic        hit_abp;
  logic        hit_eoi;
  logic        hit_dir;
  logic        eff_bypdis;
  logic        fast_sig;
  logic [2:0]  bp_inc;

  // Security of the access; a single-state part treats all as secure
  assign ns_acc    = TWO_SEC && nonsecure_i;
  assign split_acc = ns_acc ? split_ns_reg : split_s_reg;
  assign hit_ctl   = (addr_i == CII_OFF_CONTROL);
  assign hit_bp    = (addr_i == CII_OFF_BINPOINT);
  assign hit_abp   = (addr_i == CII_OFF_ALIAS_BP);
  assign hit_eoi   = (addr_i == CII_OFF_END_OF_INT) ||
                     (TWO_SEC && addr_i == CII_OFF_ALIAS_EOI);          // alias
  assign hit_dir   = (addr_i == CII_OFF_DEACTIVATE);
  // Without legacy lines the disable reads as one and cannot be cleared
  assign eff_bypdis = LEGACY ? bypdis_reg : 1'b1;
  assign bp_inc    = (bp_s_reg == CII_BP_MAX) ? CII_BP_MAX : 3'(bp_s_reg + 3'h1);
  assign fast_sig  = grp0_en_reg && route_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Control and binary point registers, read path

  always_comb begin
    grp0_en_next  = grp0_en_reg;
    grp1_en_next  = grp1_en_reg;
    route_next    = route_reg;
    cbp_next      = cbp_reg;
    bypdis_next   = bypdis_reg;
    split_s_next  = split_s_reg;
    split_ns_next = split_ns_reg;
    bp_s_next     = bp_s_reg;
    bp_ns_next    = bp_ns_reg;
    rdata_next    = CII_RD_ZERO;
    rvalid_next   = rd_en_i;
    if (wr_en_i && hit_ctl) begin
      if (ns_acc) begin
        // Non-secure view holds only its own enable and mode bit
        grp1_en_next  = wdata_i[CII_BIT_GRP0_EN];
        split_ns_next = wdata_i[CII_BIT_SPLIT_S];
      end else begin
        grp0_en_next  = wdata_i[CII_BIT_GRP0_EN];
        grp1_en_next  = wdata_i[CII_BIT_GRP1_EN];
        route_next    = wdata_i[CII_BIT_FAST_ROUTE];
        cbp_next      = wdata_i[CII_BIT_COMMON_BP];
        bypdis_next   = wdata_i[CII_BIT_FAST_BYP_DIS];
        split_s_next  = wdata_i[CII_BIT_SPLIT_S];
        if (TWO_SEC) begin
          split_ns_next = wdata_i[CII_BIT_SPLIT_NS];
        end
      end
    end
    if (wr_en_i && hit_bp) begin
      if (!ns_acc) begin
        bp_s_next = wdata_i[2:0];
      end else if (!cbp_reg) begin
        bp_ns_next = wdata_i[2:0];                                       // dropped if common
      end
    end
    if (wr_en_i && hit_abp && !ns_acc) begin
      bp_ns_next = wdata_i[2:0];
    end
    if (rd_en_i && hit_ctl) begin
      if (ns_acc) begin
        rdata_next[CII_BIT_GRP0_EN] = grp1_en_reg;
        rdata_next[CII_BIT_SPLIT_S] = split_ns_reg;
      end else begin
        rdata_next[CII_BIT_GRP0_EN]      = grp0_en_reg;
        rdata_next[CII_BIT_GRP1_EN]      = grp1_en_reg;                  // bit 2 stays zero
        rdata_next[CII_BIT_FAST_ROUTE]   = route_reg;
        rdata_next[CII_BIT_COMMON_BP]    = cbp_reg;
        rdata_next[CII_BIT_FAST_BYP_DIS] = eff_bypdis;
        rdata_next[CII_BIT_SPLIT_S]      = split_s_reg;
        rdata_next[CII_BIT_SPLIT_NS]     = TWO_SEC ? split_ns_reg : 1'b0;
      end
    end
    if (rd_en_i && hit_bp) begin
      if (ns_acc && cbp_reg) begin
        rdata_next[2:0] = bp_inc;
      end else begin
        rdata_next[2:0] = ns_acc ? bp_ns_reg : bp_s_reg;
      end
    end
    if (rd_en_i && hit_abp && !ns_acc) begin
      rdata_next[2:0] = bp_ns_reg;
    end
  end

  // Registering only; reset clears every control field
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      grp0_en_reg  <= CII_RST_FIELD;
      grp1_en_reg  <= CII_RST_FIELD;
      route_reg    <= CII_RST_FIELD;
      cbp_reg      <= CII_RST_FIELD;
      bypdis_reg   <= CII_RST_FIELD;
      split_s_reg  <= CII_RST_FIELD;
      split_ns_reg <= CII_RST_FIELD;
      bp_s_reg     <= CII_RST_BP;
      bp_ns_reg    <= CII_RST_BP;
      rdata_reg    <= CII_RD_ZERO;
      rvalid_reg   <= 1'b0;
    end else begin
      grp0_en_reg  <= grp0_en_next;
      grp1_en_reg  <= grp1_en_next;
      route_reg    <= route_next;
      cbp_reg      <= cbp_next;
      bypdis_reg   <= bypdis_next;
      split_s_reg  <= split_s_next;
      split_ns_reg <= split_ns_next;
      bp_s_reg     <= bp_s_next;
      bp_ns_reg    <= bp_ns_next;
      rdata_reg    <= rdata_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line signaling and preemption point selection

  always_comb begin
    irq_next = (grp1_en_reg && grp1_pending_i) ||
               (grp0_en_reg && !route_reg && grp0_pending_i);
    if (fast_sig) begin
      fiq_next = grp0_pending_i;
    end else if (sre_el1_i) begin
      fiq_next = bypass_fiq_i;                                           // field ignored
    end else begin
      fiq_next = bypass_fiq_i && !eff_bypdis;
    end
    bp0_next = bp_s_reg;
    bp1_next = cbp_reg ? bp_s_reg : bp_ns_reg;
  end

  // Registering only, so the lines change a cycle after their cause
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      irq_reg <= 1'b0;
      fiq_reg <= 1'b0;
      bp0_reg <= CII_RST_BP;
      bp1_reg <= CII_RST_BP;
    end else begin
      irq_reg <= irq_next;
      fiq_reg <= fiq_next;
      bp0_reg <= bp0_next;
      bp1_reg <= bp1_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Completion and deactivate writes; ids are assumed acknowledged earlier

  always_comb begin
    drop_next   = 1'b0;
    deact_next  = 1'b0;
    grp1_next   = grp1_reg;
    id_next     = id_reg;
    clr_s_next  = 1'b0;
    clr_ns_next = 1'b0;
    err_next    = 1'b0;
    if (wr_en_i && hit_dir) begin
      if (split_acc) begin
        deact_next = 1'b1;                                               // no drop
        id_next    = id_if.interrupt_identifier;
        grp1_next  = ns_acc;
      end else begin
        err_next = 1'b1;
      end
    end
    if (wr_en_i && hit_eoi && !id_if.special) begin
      if (TWO_SEC && !ns_acc && id_group1_i) begin
        err_next   = 1'b1;
        clr_s_next = hp_active_secure_i;
      end else if (ns_acc && !id_group1_i && split_s_reg) begin
        err_next    = 1'b1;
        clr_ns_next = !hp_active_secure_i;
      end else begin
        drop_next  = 1'b1;
        deact_next = !split_acc;
        id_next    = id_if.interrupt_identifier;
        grp1_next  = ns_acc;
      end
    end
  end

  // Registering only; event outputs are one-cycle pulses
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      drop_reg   <= 1'b0;
      deact_reg  <= 1'b0;
      grp1_reg   <= 1'b0;
      id_reg     <= 24'h00_0000;
      clr_s_reg  <= 1'b0;
      clr_ns_reg <= 1'b0;
      err_reg    <= 1'b0;
    end else begin
      drop_reg   <= drop_next;
      deact_reg  <= deact_next;
      grp1_reg   <= grp1_next;
      id_reg     <= id_next;
      clr_s_reg  <= clr_s_next;
      clr_ns_reg <= clr_ns_next;
      err_reg    <= err_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops

  assign rdata_o          = rdata_reg;
  assign rd_valid_o       = rvalid_reg;
  assign irq_o            = irq_reg;
  assign fiq_o            = fiq_reg;
  assign drop_o           = drop_reg;
  assign deact_o          = deact_reg;
  assign group1_o         = grp1_reg;
  assign int_id_o         = id_reg;
  assign clr_s_highest_o  = clr_s_reg;
  assign clr_ns_highest_o = clr_ns_reg;
  assign sys_err_o        = err_reg;
  assign grp0_bp_o        = bp0_reg;
  assign grp1_bp_o        = bp1_reg;

endmodule : cii_cpu_iface

// [verilog/cii_pkg.sv]
// Package of constants for the interrupt CPU interface control and completion block
package cii_pkg;

  // Register offsets on the memory-mapped port (byte addresses)
  localparam logic [15:0] CII_OFF_CONTROL     = 16'h0000;
  localparam logic [15:0] CII_OFF_BINPOINT    = 16'h0008;
  localparam logic [15:0] CII_OFF_END_OF_INT  = 16'h0010;
  localparam logic [15:0] CII_OFF_ALIAS_BP    = 16'h001C;
  localparam logic [15:0] CII_OFF_ALIAS_EOI   = 16'h0024;
  localparam logic [15:0] CII_OFF_DEACTIVATE  = 16'h1000;

  // Control register field positions, secure or single-state view
  localparam int CII_BIT_GRP0_EN      = 0;
  localparam int CII_BIT_GRP1_EN      = 1;
  localparam int CII_BIT_FAST_ROUTE   = 3;
  localparam int CII_BIT_COMMON_BP    = 4;
  localparam int CII_BIT_FAST_BYP_DIS = 5;
  localparam int CII_BIT_SPLIT_S      = 9;
  localparam int CII_BIT_SPLIT_NS     = 10;

  // Reset values
  localparam logic       CII_RST_FIELD = 1'h0;
  localparam logic [2:0] CII_RST_BP    = 3'h2;
  localparam logic [31:0] CII_RD_ZERO  = 32'h0000_0000;

  // Identifier layout and binary point limit
  localparam logic [9:0] CII_ID_SPECIAL_MIN = 10'h3FC;
  localparam logic [9:0] CII_ID_SGI_MAX     = 10'h00F;
  localparam logic [2:0] CII_BP_MAX         = 3'h7;

endpackage : cii_pkg

// [verilog/cii_id_if.sv]
// Interface carrying a written word to the identifier decoder and back
interface cii_id_if;
  logic [31:0] raw;
  logic [23:0] interrupt_identifier;
  logic        special;

  modport dec (input raw, output interrupt_identifier, output special);
  modport usr (output raw, input interrupt_identifier, input special);
endinterface : cii_id_if

// [verilog/cii_id_decode.sv]
// Identifier decoder for completion and deactivate writes
module cii_id_decode
  import cii_pkg::*;
(
  cii_id_if.dec id_if
);

  logic [9:0] low_id;

  // Reserved upper bits are dropped; source field kept only for software interrupts
  always_comb begin
    low_id        = id_if.raw[9:0];
    id_if.interrupt_identifier   = 24'h00_0000;                          // [31:24] dropped
    id_if.interrupt_identifier[9:0] = low_id;                            // [23:13] reserved zero
    if (low_id <= CII_ID_SGI_MAX) begin
      id_if.interrupt_identifier[12:10] = id_if.raw[12:10];              // source interface
    end else begin
      id_if.interrupt_identifier[12:10] = 3'h0;
    end
    id_if.special = (low_id >= CII_ID_SPECIAL_MIN);       // 1020..1023
  end

endmodule : cii_id_decode

// [tb/cii_cpu_iface_props.sv]
// Port checker for the interrupt CPU interface, bound to its top module
module cii_cpu_iface_props
  import cii_pkg::*;
#(
  parameter bit TWO_SEC = 1'b1
) (
  input wire logic        mclk_i,
  input wire logic        resetn_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        nonsecure_i,
  input wire logic        id_group1_i,
  input wire logic        rd_valid_o,
  input wire logic        drop_o,
  input wire logic        deact_o,
  input wire logic [23:0] int_id_o,
  input wire logic        sys_err_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] exp_id_reg;
  logic [23:0] exp_id_next;
  logic        eoi_wr;
  logic        spec_wr;
  logic        dir_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Identifier the next drop must carry; source bits only for low identifiers
  always_comb begin
    exp_id_next = {11'h000, wdata_i[12:10], wdata_i[9:0]};
    if (wdata_i[9:0] > CII_ID_SGI_MAX) exp_id_next[12:10] = 3'h0;
  end

  always_ff @(posedge mclk_i) begin
    exp_id_reg <= exp_id_next;
  end

  // Write decode seen from the bus
  assign eoi_wr  = wr_en_i && addr_i == CII_OFF_END_OF_INT;
  assign spec_wr = eoi_wr && wdata_i[9:0] >= CII_ID_SPECIAL_MIN;
  assign dir_wr  = wr_en_i && addr_i == CII_OFF_DEACTIVATE;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_read_answer: assert property (rd_en_i |=> rd_valid_o)
    else $error("read not answered");
  a_read_cause: assert property (rd_valid_o |-> $past(rd_en_i))
    else $error("read answer without read");
  a_eoi_drop_id: assert property (eoi_wr && !spec_wr && !nonsecure_i && !id_group1_i
    |=> drop_o && int_id_o == exp_id_reg) else $error("completion did not drop");
  a_special_ignored: assert property (spec_wr |=> !drop_o && !deact_o && !sys_err_o)
    else $error("special identifier acted on");
  a_dir_one_outcome: assert property (dir_wr |=> (deact_o != sys_err_o) && !drop_o)
    else $error("deactivate outcome wrong");
  a_sec_grp1_refused: assert property (TWO_SEC && eoi_wr && !spec_wr && !nonsecure_i
    && id_group1_i |=> sys_err_o && !drop_o && !deact_o) else $error("group 1 completion acted");
  a_id_upper_zero: assert property ((drop_o || deact_o) |-> int_id_o[23:13] == 11'h000)
    else $error("reserved identifier bits set");
  a_drop_cause: assert property (drop_o |-> $past(wr_en_i) && !$past(dir_wr))
    else $error("drop without completion write");

  // Main scenarios reached
  c_drop_deact: cover property (drop_o && deact_o);
  c_lone_deact: cover property (deact_o && !drop_o);
  c_refused: cover property (sys_err_o);
endmodule : cii_cpu_iface_props

bind cii_cpu_iface cii_cpu_iface_props #(.TWO_SEC(TWO_SEC)) i_props (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .nonsecure_i(nonsecure_i), .id_group1_i(id_group1_i),
  .rd_valid_o(rd_valid_o), .drop_o(drop_o), .deact_o(deact_o), .int_id_o(int_id_o),
  .sys_err_o(sys_err_o)
);

// [tb/cii_core_model.sv]
// Behavioural processor core making register accesses and completions
module cii_core_model (
  input  wire logic        mclk_i,
  output logic             wr_en_o,
  output logic             rd_en_o,
  output logic      [15:0] addr_o,
  output logic      [31:0] wdata_o,
  output logic             nonsecure_o,
  output logic             group1_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] ack_q[$];

  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 32'h0000_0000;
    nonsecure_o = 1'b0;
    group1_o = 1'b0;
  end

  // One write held across its taking edge; released lines other than the security line show the inverse
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic n, input logic g);
    @(posedge mclk_i);
    #1 {wr_en_o, addr_o, wdata_o, nonsecure_o, group1_o} = {1'b1, a, d, n, g};
    @(posedge mclk_i);
    #1 {wr_en_o, addr_o, wdata_o, group1_o} = {1'b0, ~a, ~d, ~g};
  endtask : wr

  // One read; the answer is registered at the edge that takes it
  task automatic rd(input logic [15:0] a, input logic n);
    @(posedge mclk_i);
    #1 {rd_en_o, addr_o, nonsecure_o} = {1'b1, a, n};
    @(posedge mclk_i);
    #1 {rd_en_o, addr_o} = {1'b0, ~a};
  endtask : rd

  // Acknowledged identifiers are stacked and each one is completed
  task automatic ack(input logic [31:0] v);
    ack_q.push_back(v);
  endtask : ack

  // Nested completions leave in reverse order of acknowledgement
  task automatic take(output logic [31:0] v);
    v = ack_q.pop_back();
  endtask : take
endmodule : cii_core_model

// [tb/tb.sv]
// Self-checking bench of the interrupt CPU interface block
module tb
  import cii_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rstn, we, re, ns, g1, sre, g0p, g1p, byp, hp;
  logic        rvld, irq, fast_interrupt_line, drop, deact, grp1, cs, cns, err;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, seed, w;
  logic [23:0] iid;
  logic [2:0]  bp0, bp1;
  int          n_errors, checked;

  cii_core_model core (.mclk_i(clk), .wr_en_o(we), .rd_en_o(re), .addr_o(addr),
    .wdata_o(wdata), .nonsecure_o(ns), .group1_o(g1));

  cii_cpu_iface i_cii_cpu_iface (.mclk_i(clk), .resetn_i(rstn), .wr_en_i(we), .rd_en_i(re),
    .addr_i(addr), .wdata_i(wdata), .nonsecure_i(ns), .id_group1_i(g1), .sre_el1_i(sre),
    .grp0_pending_i(g0p), .grp1_pending_i(g1p), .bypass_fiq_i(byp),
    .hp_active_secure_i(hp), .rdata_o(rdata), .rd_valid_o(rvld), .irq_o(irq), .fiq_o(fast_interrupt_line),
    .drop_o(drop), .deact_o(deact), .group1_o(grp1), .int_id_o(iid),
    .clr_s_highest_o(cs), .clr_ns_highest_o(cns), .sys_err_o(err), .grp0_bp_o(bp0),
    .grp1_bp_o(bp1));

  ////////////////////////////////////////////////////////////////////////////
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected identifier: source bits survive only for low identifiers
  function automatic logic [23:0] exp_id(input logic [31:0] v);
    return {11'h000, (v[9:0] <= CII_ID_SGI_MAX) ? v[12:10] : 3'h0, v[9:0]};
  endfunction : exp_id

  // Expected {normal, fast} lines for a control word and the present inputs
  function automatic logic [1:0] exp_lines(input logic [31:0] c);
    return {(c[1] && g1p) || (c[0] && !c[3] && g0p),
            (c[0] && c[3]) ? g0p : (byp && (!c[5] || sre))};
  endfunction : exp_lines

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Write one word, then compare {drop, deact, error, clear secure, clear non-secure}
  task automatic eoi(input logic [15:0] a, input logic n, input logic g, input logic [31:0] v,
                     input logic [4:0] ev);
    core.wr(a, v, n, g);
    chk("events", {27'h0, ev}, {27'h0, drop, deact, err, cs, cns});
    if (ev[4] || ev[3]) chk("id", {7'h0, n, exp_id(v)}, {7'h0, grp1, iid});
  endtask : eoi

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    n_errors++;
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {seed, n_errors, checked} = {32'h0000_000C, 32'h0, 32'h0};
    {rstn, sre, g0p, g1p, byp, hp} = 6'h00;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    chk("bp", 32'h12, {26'h0, bp0, bp1});
    core.rd(CII_OFF_CONTROL, 1'b0);
    chk("control", 32'h0, rdata);
    // Random control words against the interrupt lines and read-back
    repeat (24) begin
      w = rnd();
      {sre, g0p, g1p, byp} = w[31:28];
      core.wr(CII_OFF_CONTROL, w, 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      #1 chk("lines", {30'h0, exp_lines(w)}, {30'h0, irq, fast_interrupt_line});
      core.rd(CII_OFF_CONTROL, 1'b0);
      chk("control", w & 32'h0000_063B, rdata);
    end
    core.wr(16'h0004, rnd(), 1'b0, 1'b0);
    core.rd(16'h0004, 1'b0);
    chk("unmapped", 32'h1, {rdata[30:0], rvld});
    // Binary points with and without the common selection
    core.wr(CII_OFF_ALIAS_BP, 32'h3, 1'b0, 1'b0);
    for (int b = 0; b < 8; b++) begin
      core.wr(CII_OFF_CONTROL, {27'h0, b[0], 4'h0}, 1'b0, 1'b0);
      core.wr(CII_OFF_BINPOINT, b, 1'b0, 1'b0);
      if (b[0]) core.wr(CII_OFF_BINPOINT, 32'h0, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      #1 chk("bp", {26'h0, b[2:0], b[0] ? b[2:0] : 3'h3}, {26'h0, bp0, bp1});
      if (b[0]) begin
        core.rd(CII_OFF_BINPOINT, 1'b1);
        chk("ns bp", (b == 7) ? 32'h7 : b + 1, rdata);
      end
    end
    // Every split-mode pairing against each kind of completion write
    for (int m = 0; m < 4; m++) begin
      core.wr(CII_OFF_CONTROL, {21'h0, m[1:0], 9'h0}, 1'b0, 1'b0);
      for (int k = 0; k < 8; k++) begin
        w = rnd() & 32'hFFFF_FDFB; // Bit 9 clear keeps ids out of the special range
        if (k[0]) w[9:4] = 6'h00;
        hp = w[31];
        case (k)
          0: eoi(CII_OFF_END_OF_INT, 1'b0, 1'b0, w, {1'b1, !m[0], 3'h0});
          1: eoi(CII_OFF_END_OF_INT, 1'b1, 1'b1, w, {1'b1, !m[1], 3'h0});
          2: eoi(CII_OFF_ALIAS_EOI, 1'b1, 1'b1, w, {1'b1, !m[1], 3'h0});
          3: eoi(CII_OFF_DEACTIVATE, 1'b0, 1'b0, w, {1'b0, m[0], !m[0], 2'h0});
          4: eoi(CII_OFF_DEACTIVATE, 1'b1, 1'b0, w, {1'b0, m[1], !m[1], 2'h0});
          5: eoi(CII_OFF_END_OF_INT, 1'b0, 1'b1, w, {3'h1, hp, 1'b0});
          6: eoi(CII_OFF_END_OF_INT, 1'b1, 1'b0, w,
                 m[0] ? {3'h1, 1'b0, !hp} : {1'b1, !m[1], 3'h0});
          default: eoi(CII_OFF_END_OF_INT, 1'b0, 1'b0,
                       {w[31:10], CII_ID_SPECIAL_MIN + m[9:0]}, 5'h00);
        endcase
      end
    end
    // Non-secure control view: enable in bit 0, mode in bit 9, rest read-only
    core.wr(CII_OFF_CONTROL, 32'hFFFF_FFFF, 1'b1, 1'b0);
    core.rd(CII_OFF_CONTROL, 1'b1);
    chk("ns control", 32'h0000_0201, rdata);
    core.rd(CII_OFF_CONTROL, 1'b0);
    chk("control", 32'h0000_0602, rdata);
    // Nested completions in split mode drop priority only
    repeat (3) core.ack(rnd() & 32'h0000_03FB);
    repeat (3) begin
      core.take(w);
      eoi(CII_OFF_END_OF_INT, 1'b0, 1'b0, w, 5'h10);
    end
    report_and_stop();
  end
endmodule : tb
